// file: hdl/scow_regs.svh
// Register offsets, fields, reset values and timing counts for the supply code link.
// Assumes a 100 MHz system clock and an internal register port with 7-bit addresses.
`ifndef SCOW_REGS_SVH
`define SCOW_REGS_SVH
`define SCOW_ADDR_TX          7'h66
`define SCOW_ADDR_STATUS      7'h6E
`define SCOW_CODE_RESET       8'hFF
`define SCOW_BUSY_BIT         8
`define SCOW_BUSY_ERR_BIT     9
`define SCOW_ACK_ERR_BIT      10
`define SCOW_CLK_NS           10
`define SCOW_BIT_NS           10000
`define SCOW_BIT_CYCLES       ((`SCOW_BIT_NS + `SCOW_CLK_NS - 1) / `SCOW_CLK_NS)
`define SCOW_LOW1_CYCLES      (`SCOW_BIT_CYCLES / 4)
`define SCOW_LOW0_CYCLES      ((`SCOW_BIT_CYCLES * 3) / 4)
`define SCOW_SAMPLE_CYCLES    (`SCOW_BIT_CYCLES / 2)
`define SCOW_FRAME_BITS       4'd9
`endif

// file: hdl/scow_pkg.sv
// Types shared by the supply code link.
// Assumes the register header is included where offsets are needed.
package scow_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b0_0001,
        ST_START = 5'b0_0010,
        ST_BIT   = 5'b0_0100,
        ST_ACK   = 5'b0_1000,
        ST_DONE  = 5'b1_0000
    } scow_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } scow_req_t;
endpackage

// file: hdl/scow_bit_timer.sv
// Bit slot timer for the one-wire frame: counts cycles within one slot.
// Assumes start pulses only while the caller is in a frame.
`timescale 1ns/1ps
`include "scow_regs.svh"
module scow_bit_timer (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        start_in,
    output logic             end_out,
    output logic [15:0]      count_out
);
    localparam logic [15:0] LAST = 16'(`SCOW_BIT_CYCLES - 1);
    logic running;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            running   <= 1'b0;
            count_out <= 16'h0000;
            end_out   <= 1'b0;
        end else begin
            end_out <= 1'b0;
            if (start_in) begin
                running   <= 1'b1;
                count_out <= 16'h0000;
            end else if (running) begin
                if (count_out == LAST) begin
                    running <= 1'b0;
                    end_out <= 1'b1;
                end else begin
                    count_out <= count_out + 16'h0001;
                end
            end
        end
    end
endmodule

// file: hdl/scow_top.sv
// Supply code transmitter: register port plus one-wire link with acknowledge.
// Assumes a host register port on the same clock and an open-drain link wire.
// Contract
// - Code field bits 7:0, resets 0xFF
// - Block code writes until transmission finishes
// - Busy bit 8 while pending or sending
// - Rejected write sets busy error bit 9
// - No acknowledge triggers exactly one retry
// - Second failure sets acknowledge error bit 10
// - Clear input pulse clears both errors
// - Status 7:0 holds last acknowledged code
// - Status register ignores all writes
`timescale 1ns/1ps
`include "scow_regs.svh"
module scow_top
    import scow_pkg::*;
(
    input  wire logic             SYS_CLK_IN,
    input  wire logic             RST_IN,
    input  wire scow_pkg::scow_req_t REQ_IN,
    input  wire logic             LINK_ERR_CLEAR_IN,
    input  wire logic             LINK_IN,
    output logic                  LINK_OUT,
    output logic                  LINK_OE_OUT,
    output logic [15:0]           RDATA_OUT,
    output logic                  RVALID_OUT
);
    import scow_pkg::*;

    localparam logic [15:0] LOW1  = 16'(`SCOW_LOW1_CYCLES);
    localparam logic [15:0] LOW0  = 16'(`SCOW_LOW0_CYCLES);
    localparam logic [15:0] SAMPL = 16'(`SCOW_SAMPLE_CYCLES);

    scow_state_t state;
    logic [7:0]  tx_code;
    logic [7:0]  last_code;
    logic        busy;
    logic        busy_err;
    logic        ack_err;
    logic [7:0]  shift;
    logic [3:0]  bit_idx;
    logic        retry;
    logic        ack_seen;
    logic        slot_start;
    logic        slot_end;
    logic [15:0] slot_cnt;
    logic        link_s1;
    logic        link_s2;
    logic        link_s3;
    logic        link_lvl;
    logic        code_wr;
    logic        next_oe;

    // Wire comes from outside: three stages, accept on agreement of last two
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            link_s1  <= 1'b1;
            link_s2  <= 1'b1;
            link_s3  <= 1'b1;
            link_lvl <= 1'b1;
        end else begin
            link_s1 <= LINK_IN;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            if (link_s2 == link_s3) begin
                link_lvl <= link_s3;
            end
        end
    end

    assign code_wr = REQ_IN.wr && (REQ_IN.addr == `SCOW_ADDR_TX);

    scow_bit_timer scow_bit_timer_i (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (RST_IN),
        .start_in  (slot_start),
        .end_out   (slot_end),
        .count_out (slot_cnt)
    );

    // Code register; writes while busy are dropped
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            tx_code <= `SCOW_CODE_RESET;
        end else if (code_wr && !busy) begin
            tx_code <= REQ_IN.wdata[7:0];
        end
    end

    // Busy error: set beats clear in the same cycle
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            busy_err <= 1'b0;
        end else if (code_wr && busy) begin
            busy_err <= 1'b1;
        end else if (LINK_ERR_CLEAR_IN) begin
            busy_err <= 1'b0;
        end
    end

    // Frame sequencer: start slot, eight data slots MSB first, ack slot
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state      <= ST_IDLE;
            busy       <= 1'b0;
            shift      <= 8'h00;
            bit_idx    <= 4'h0;
            retry      <= 1'b0;
            ack_seen   <= 1'b0;
            slot_start <= 1'b0;
            last_code  <= `SCOW_CODE_RESET;
            ack_err    <= 1'b0;
        end else begin
            slot_start <= 1'b0;
            if (LINK_ERR_CLEAR_IN) begin
                ack_err <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (code_wr && !busy) begin
                        busy       <= 1'b1;
                        retry      <= 1'b0;
                        state      <= ST_START;
                        slot_start <= 1'b1;
                    end
                end
                ST_START: begin
                    if (slot_end) begin
                        shift      <= tx_code;
                        bit_idx    <= 4'h0;
                        state      <= ST_BIT;
                        slot_start <= 1'b1;
                    end
                end
                ST_BIT: begin
                    if (slot_end) begin
                        shift      <= {shift[6:0], 1'b0};
                        bit_idx    <= bit_idx + 4'h1;
                        slot_start <= 1'b1;
                        if (bit_idx == (`SCOW_FRAME_BITS - 4'd2)) begin
                            state    <= ST_ACK;
                            ack_seen <= 1'b0;
                        end
                    end
                end
                ST_ACK: begin
                    if (slot_cnt > SAMPL && !link_lvl) begin
                        ack_seen <= 1'b1;
                    end
                    if (slot_end) begin
                        if (ack_seen) begin
                            last_code <= tx_code;
                            state     <= ST_DONE;
                        end else if (!retry) begin
                            retry      <= 1'b1;
                            state      <= ST_START;
                            slot_start <= 1'b1;
                        end else begin
                            ack_err <= 1'b1;
                            state   <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    busy  <= 1'b0;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: pull low at slot start, length encodes the bit
    always_comb begin
        next_oe = 1'b0;
        case (state)
            ST_START: next_oe = !slot_start;
            ST_BIT:   next_oe = !slot_start && (slot_cnt < (shift[7] ? LOW1 : LOW0));
            ST_ACK:   next_oe = !slot_start && (slot_cnt < LOW1);
            default:  next_oe = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            LINK_OE_OUT <= 1'b0;
            LINK_OUT    <= 1'b0;
        end else begin
            LINK_OE_OUT <= next_oe;
            LINK_OUT    <= 1'b0;
        end
    end

    // Read port; status register has no write path at all
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            RDATA_OUT  <= 16'h0000;
            RVALID_OUT <= 1'b0;
        end else begin
            RVALID_OUT <= REQ_IN.rd;
            RDATA_OUT  <= 16'h0000;
            if (REQ_IN.rd && REQ_IN.addr == `SCOW_ADDR_TX) begin
                RDATA_OUT <= {8'h00, tx_code};
            end else if (REQ_IN.rd && REQ_IN.addr == `SCOW_ADDR_STATUS) begin
                RDATA_OUT <= {5'h00, ack_err, busy_err, busy, last_code};
            end
        end
    end

    AST_WRITE_BLOCKED: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (code_wr && busy) |=> $stable(tx_code))
        else $error("Code changed by write while busy");

    AST_CODE_ONLY_WR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !$stable(tx_code) |-> ($past(code_wr) && !$past(busy)))
        else $error("Code changed without accepted write");

    AST_CODE_RESET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $fell(RST_IN) |-> (tx_code == `SCOW_CODE_RESET && last_code == `SCOW_CODE_RESET))
        else $error("Code fields not at reset value");

    AST_BUSY_SET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (code_wr && !busy) |=> busy)
        else $error("Busy not set after accepted write");

    AST_BUSY_CAUSE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $rose(busy) |-> $past(code_wr))
        else $error("Busy raised without accepted write");

    AST_BUSY_HOLDS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (busy && state != ST_DONE) |=> busy)
        else $error("Busy dropped before sequence end");

    AST_IDLE_FREE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_IDLE) |-> !busy)
        else $error("Busy while idle");

    AST_BUSY_ERR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (code_wr && busy) |=> busy_err)
        else $error("Busy error not set");

    AST_BUSY_ERR_CAUSE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $rose(busy_err) |-> ($past(code_wr) && $past(busy)))
        else $error("Busy error without blocked write");

    AST_RETRY: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && slot_end && !ack_seen && !retry) |=> (state == ST_START && busy))
        else $error("No retry after missing acknowledge");

    AST_RETRY_ONCE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && slot_end && !ack_seen && retry) |=> (state == ST_DONE))
        else $error("More than one retry");

    AST_ACK_ERR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && slot_end && !ack_seen && retry) |=> ack_err)
        else $error("Acknowledge error not set");

    AST_ACK_ERR_CAUSE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $rose(ack_err) |-> ($past(state) == ST_ACK && $past(slot_end)
            && $past(retry) && !$past(ack_seen)))
        else $error("Acknowledge error without second failure");

    AST_CLEAR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (LINK_ERR_CLEAR_IN && !code_wr && !(state == ST_ACK && slot_end))
            |=> (!busy_err && !ack_err))
        else $error("Errors not cleared");

    AST_LAST_CODE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && slot_end && ack_seen) |=> (last_code == tx_code))
        else $error("Last code not updated");

    AST_STATUS_READ: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (REQ_IN.rd && REQ_IN.addr == `SCOW_ADDR_STATUS)
            |=> (RDATA_OUT[7:0] == $past(last_code) && RDATA_OUT[8] == $past(busy)))
        else $error("Status read data wrong");

    AST_TX_READ: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (REQ_IN.rd && REQ_IN.addr == `SCOW_ADDR_TX)
            |=> (RDATA_OUT == {8'h00, $past(tx_code)}))
        else $error("Code readback wrong");

    AST_STATUS_RO: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (REQ_IN.wr && REQ_IN.addr == `SCOW_ADDR_STATUS && state == ST_IDLE
            && !LINK_ERR_CLEAR_IN) |=> ($stable(busy) && $stable(busy_err)
            && $stable(ack_err) && $stable(last_code)))
        else $error("Status changed by a write");

    AST_FAIL_KEEPS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && slot_end && !ack_seen) |=> $stable(last_code))
        else $error("Last code changed on failure");

    AST_BUSY_CLEAR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_DONE) |=> (!busy && state == ST_IDLE))
        else $error("Busy not cleared at end");

    AST_IDLE_RELEASED: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_IDLE) |=> !LINK_OE_OUT)
        else $error("Wire pulled while idle");

    AST_START_LOW: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_START && !slot_start) |=> LINK_OE_OUT)
        else $error("Start slot not pulled low");

    AST_ACK_RELEASE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state == ST_ACK && !slot_start && slot_cnt > SAMPL) |=> !LINK_OE_OUT)
        else $error("Wire still pulled at acknowledge sample");
endmodule

// file: tb/scow_partner.sv
// Power companion model: decodes link frames and answers the ack slot.
// Assumes the wire is pulled up and the device only ever pulls it low.
`timescale 1ns/1ps
module scow_partner (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       link_oe_in,
    input  wire logic       ack_en_in,
    output logic            ack_low_out,
    output logic [7:0]      byte_out,
    output logic [7:0]      frames_out
);
    logic [15:0] low_len;
    logic [15:0] hold;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        oe_q;

    assign ack_low_out = (hold != 16'h0000);
    always_ff @(posedge clk_in) begin
        oe_q <= link_oe_in;
        if (rst_in) begin
            low_len    <= 16'h0000;
            hold       <= 16'h0000;
            bit_cnt    <= 4'h0;
            shift      <= 8'h00;
            byte_out   <= 8'h00;
            frames_out <= 8'h00;
        end else begin
            if (link_oe_in) low_len <= low_len + 16'h0001;
            if (hold != 16'h0000) hold <= hold - 16'h0001;
            if (oe_q && !link_oe_in) begin
                low_len <= 16'h0000;
                if (low_len > 16'h0384) begin
                    bit_cnt <= 4'h0;
                end else if (bit_cnt < 4'h8) begin
                    shift   <= {shift[6:0], low_len < 16'h01F4};
                    bit_cnt <= bit_cnt + 4'h1;
                end else begin
                    // Held well past the device's sample point in the slot
                    if (ack_en_in) hold <= 16'h01F4;
                    byte_out   <= shift;
                    frames_out <= frames_out + 8'h01;
                    bit_cnt    <= 4'h0;
                end
            end
        end
    end
endmodule

// file: tb/scow_top_bench.sv
// Self-checking bench for the supply code transmitter and its partner.
// Assumes a 100 MHz clock and a pulled-up open-drain link wire.
`timescale 1ns/1ps
`include "scow_regs.svh"
module scow_top_bench;
    import scow_pkg::*;
    logic        clk;
    logic        rst;
    scow_req_t   req;
    logic        err_clr;
    logic        ack_en;
    logic        link_out;
    logic        link_oe;
    logic        ack_low;
    logic        wire_lvl;
    logic [15:0] rdata;
    logic        rvalid;
    logic [7:0]  rx_byte;
    logic [7:0]  frames;
    logic [7:0]  base;
    logic [15:0] rd_v;
    int          error_cnt;
    int          checks_done;

    assign wire_lvl = link_oe ? link_out : ~ack_low;
    scow_top scow_top_i (.SYS_CLK_IN(clk), .RST_IN(rst), .REQ_IN(req),
        .LINK_ERR_CLEAR_IN(err_clr), .LINK_IN(wire_lvl), .LINK_OUT(link_out),
        .LINK_OE_OUT(link_oe), .RDATA_OUT(rdata), .RVALID_OUT(rvalid));
    scow_partner scow_partner_i (.clk_in(clk), .rst_in(rst), .link_oe_in(link_oe),
        .ack_en_in(ack_en), .ack_low_out(ack_low), .byte_out(rx_byte), .frames_out(frames));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic reg_rd(input logic [6:0] a);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        req <= '0;
        rd_v = 16'hDEAD;
        repeat (3) begin
            #1;
            if (rvalid === 1'b1) rd_v = rdata;
            @(posedge clk);
        end
    endtask
    task automatic expect_rd(input logic [6:0] a, input logic [15:0] exp);
        reg_rd(a);
        check(rd_v, exp);
    endtask
    task automatic pulse_clear();
        @(posedge clk);
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
    endtask
    // Polls busy; bounded so a stuck flag cannot hang the run
    task automatic wait_idle();
        int n;
        n = 0;
        reg_rd(`SCOW_ADDR_STATUS);
        while (rd_v[8] !== 1'b0 && n < 12000) begin
            reg_rd(`SCOW_ADDR_STATUS);
            n++;
        end
        if (n >= 12000) error_cnt++;
    endtask

    task automatic t_reset();
        expect_rd(`SCOW_ADDR_TX, 16'h00FF);
        expect_rd(`SCOW_ADDR_STATUS, 16'h00FF);
        expect_rd(7'h10, 16'h0000);
        reg_wr(`SCOW_ADDR_STATUS, 16'hFFFF);
        expect_rd(`SCOW_ADDR_STATUS, 16'h00FF);
    endtask
    task automatic t_send_ok();
        reg_wr(`SCOW_ADDR_TX, 16'h12A5);
        expect_rd(`SCOW_ADDR_STATUS, 16'h01FF);
        expect_rd(`SCOW_ADDR_TX, 16'h00A5);
        check({14'h0000, link_oe, link_out}, 16'h0002);
        reg_wr(`SCOW_ADDR_TX, 16'h005A);
        expect_rd(`SCOW_ADDR_TX, 16'h00A5);
        expect_rd(`SCOW_ADDR_STATUS, 16'h03FF);
        pulse_clear();
        expect_rd(`SCOW_ADDR_STATUS, 16'h01FF);
        wait_idle();
        expect_rd(`SCOW_ADDR_STATUS, 16'h00A5);
        check({14'h0000, link_oe, link_out}, 16'h0000);
        check({8'h00, rx_byte}, 16'h00A5);
        check({8'h00, frames}, 16'h0001);
    endtask
    task automatic t_nack();
        @(posedge clk);
        ack_en <= 1'b0;
        base = frames;
        wait_idle();
        reg_wr(`SCOW_ADDR_TX, 16'h003C);
        repeat (12000) @(posedge clk);
        expect_rd(`SCOW_ADDR_STATUS, 16'h01A5);
        wait_idle();
        expect_rd(`SCOW_ADDR_STATUS, 16'h04A5);
        check({8'h00, frames - base}, 16'h0002);
        check({8'h00, rx_byte}, 16'h003C);
        pulse_clear();
        expect_rd(`SCOW_ADDR_STATUS, 16'h00A5);
    endtask
    // Reset inside a start slot must release the wire and restore both codes
    task automatic t_mid_reset();
        @(posedge clk);
        ack_en <= 1'b1;
        reg_wr(`SCOW_ADDR_TX, 16'h00C3);
        expect_rd(`SCOW_ADDR_STATUS, 16'h01A5);
        check({15'h0000, link_oe}, 16'h0001);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check({15'h0000, link_oe}, 16'h0000);
        rst <= 1'b0;
        expect_rd(`SCOW_ADDR_TX, 16'h00FF);
        expect_rd(`SCOW_ADDR_STATUS, 16'h00FF);
        reg_wr(`SCOW_ADDR_TX, 16'h00C3);
        wait_idle();
        expect_rd(`SCOW_ADDR_STATUS, 16'h00C3);
        check({8'h00, rx_byte}, 16'h00C3);
        check({8'h00, frames}, 16'h0001);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #(80000 * 10);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        rst = 1'b1;
        req = '0;
        err_clr = 1'b0;
        ack_en = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_send_ok();
        t_nack();
        t_mid_reset();
        tally_and_finish();
    end
endmodule
